// >>> logic/nvm_program_controller.sv
// nvm controller: mapped lock byte and flash sections, command sequencer, wishbone slave
//
// Functional notes
// RQ1 - reset copies calibration low byte into trim
// RQ2 - lock byte and sections mapped in data space
// RQ3 - loaded command starts on mapped data write
// RQ4 - busy flag held until operation fully done
// RQ5 - command register writes ignored while busy
// RQ6 - busy blocks other programming, reads, buffer loads
// RQ7 - internal processor writes and erases always fail
// RQ8 - upper bits section, then page, then word
// RQ9 - address bit zero picks low or high byte
// RQ10 - programmer erases a word before writing it
// RQ11 - low byte buffers, high byte starts write
// RQ12 - programmer writes low then high, same word
// RQ13 - erase only whole sections, never pages
// RQ14 - chip erase clears code, then lock bits
// RQ15 - chip erase command triggered by code high byte
// RQ16 - section erase on code word erases code
// RQ17 - section erase on config word erases config
// RQ18 - word write command programs code or config word
// RQ19 - lock written by low value, dummy high
// RQ20 - lock byte readable at its mapped location
// RQ21 - programmer polls busy before next nvm access
// RQ22 - access key sets the nvm enabled flag
// RQ23 - programmer clears enable before releasing reset
// RQ24 - config latched at reset or programming exit
// RQ25 - lock modes block programming and verification
// RQ26 - busy is bit seven, set at start
// RQ27 - six bit command field resets to no-op
// RQ28 - no-op command starts nothing on writes
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "nvm_regs.svh"
module nvm_program_controller #(
   parameter logic [7:0] CAL_VALUE = 8'h80,  // oscillator calibration byte
   parameter logic [7:0] SIG_MFR   = 8'h11,  // arbitrary value
   parameter logic [7:0] SIG_ID1   = 8'h22,  // arbitrary value
   parameter logic [7:0] SIG_ID2   = 8'h33   // arbitrary value
) (
   input  wire logic        i_clk,         // 10 MHz system clock
   input  wire logic        i_srst,        // synchronous reset, active high
   input  wire logic        i_wb_cyc,      // wishbone cycle
   input  wire logic        i_wb_stb,      // wishbone strobe
   input  wire logic        i_wb_we,       // wishbone write enable
   input  wire logic [15:0] i_wb_adr,      // data-space byte address
   input  wire logic [7:0]  i_wb_dat,      // write data
   input  wire logic [0:0]  i_wb_sel,      // byte select
   input  wire logic        i_ext_access,  // master is the external programmer
   output logic      [7:0]  o_wb_dat,      // read data
   output logic             o_wb_ack,      // wishbone acknowledge
   output logic      [7:0]  o_osc_trim,    // oscillator trim value
   output logic      [7:0]  o_cfg_byte,    // latched configuration byte
   output logic             o_nvm_busy     // nvm busy flag mirror
);
   // bus slave state
   logic        ack_r, ack_nxt;
   logic [7:0]  rdat_r, rdat_nxt;
   // control registers
   logic [5:0]  cmd_r, cmd_nxt;
   logic        en_r, en_nxt;
   logic [7:0]  trim_r, trim_nxt;
   logic [7:0]  cfg_r, cfg_nxt;
   logic [7:0]  tmp_r, tmp_nxt;
   // sequencer
   nvm_pkg::nvm_state_e state_r, state_nxt;
   nvm_pkg::nvm_op_e    op_r, op_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [8:0]  word_in_page_index_r, word_in_page_index_nxt;
   nvm_pkg::nvm_word_t wdata_r, wdata_nxt;
   logic        busy_r, busy_nxt;
   // non-volatile lock byte
   logic [7:0]  lock_r, lock_nxt;

   logic        req, commit, start_c;
   nvm_pkg::nvm_section_e sec;
   nvm_pkg::nvm_word_t code_rd, cfg_rd, cfg_w0, cal_word, sig_word, sel_word;
   logic        prog_locked, verify_locked, op_done;
   logic        code_wr, code_er, cfg_wr, cfg_er;

   assign req    = i_wb_cyc && i_wb_stb;
   assign commit = req && ack_r && i_wb_we && i_wb_sel[0];

   // upper bits pick the part; word and page bits go to the arrays
   always_comb begin
      sec = nvm_pkg::SEC_NONE;
      if (i_wb_adr[15:1] == `NVM_LOCK_SEL) begin
         sec = nvm_pkg::SEC_LOCK; // RQ2
      end else if (i_wb_adr[15:4] == `NVM_CFG_SEL) begin
         sec = nvm_pkg::SEC_CFG;
      end else if (i_wb_adr[15:4] == `NVM_CAL_SEL) begin
         sec = nvm_pkg::SEC_CAL;
      end else if (i_wb_adr[15:5] == `NVM_SIG_SEL) begin
         sec = nvm_pkg::SEC_SIG;
      end else if (i_wb_adr[15:10] == `NVM_CODE_SEL) begin
         sec = nvm_pkg::SEC_CODE;
      end
   end

   assign prog_locked   = !lock_r[0];              // RQ25
   assign verify_locked = !lock_r[0] && !lock_r[1]; // RQ25

   // read-only sections are fixed contents
   always_comb begin
      cal_word = (i_wb_adr[3:1] == 3'h0) ? {8'hff, CAL_VALUE} : `NVM_WORD_ERASED;
      unique case (i_wb_adr[4:1])
         4'h0:    sig_word = {SIG_ID1, SIG_MFR};
         4'h1:    sig_word = {8'hff, SIG_ID2};
         default: sig_word = `NVM_WORD_ERASED;
      endcase
   end

   always_comb begin
      unique case (sec)
         nvm_pkg::SEC_CODE: sel_word = code_rd;
         nvm_pkg::SEC_CFG:  sel_word = cfg_rd;
         nvm_pkg::SEC_CAL:  sel_word = cal_word;
         nvm_pkg::SEC_SIG:  sel_word = sig_word;
         nvm_pkg::SEC_LOCK: sel_word = {8'hff, lock_r}; // RQ20
         default:           sel_word = 16'h0000;
      endcase
   end

   // bus slave: ack one cycle after the request, writes act at the ack edge
   always_comb begin
      ack_nxt  = req && !ack_r;
      rdat_nxt = rdat_r;
      if (req && !ack_r) begin
         rdat_nxt = 8'h00;
         if (sec == nvm_pkg::SEC_NONE) begin
            unique case (i_wb_adr)
               `NVM_ADDR_CSR:  rdat_nxt = {busy_r, 7'h00};
               `NVM_ADDR_CMD:  rdat_nxt = {2'h0, cmd_r};
               `NVM_ADDR_LINK: rdat_nxt = {6'h00, en_r, 1'b0};
               `NVM_ADDR_TRIM: rdat_nxt = trim_r;
               default:        rdat_nxt = 8'h00;
            endcase
         end else if (busy_r) begin
            rdat_nxt = 8'h00; // RQ6
         end else if (verify_locked && (sec == nvm_pkg::SEC_CODE || sec == nvm_pkg::SEC_CFG)) begin
            rdat_nxt = 8'hff; // RQ25
         end else begin
            rdat_nxt = i_wb_adr[0] ? sel_word[15:8] : sel_word[7:0]; // RQ9
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ack_r  <= 1'b0;
         rdat_r <= 8'h00;
      end else begin
         ack_r  <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   // register writes and command start
   always_comb begin
      cmd_nxt   = cmd_r;
      en_nxt    = en_r;
      trim_nxt  = trim_r;
      tmp_nxt   = tmp_r;
      cfg_nxt   = cfg_r;
      start_c   = 1'b0;
      op_nxt    = op_r;
      word_in_page_index_nxt = word_in_page_index_r;
      wdata_nxt = wdata_r;
      if (commit) begin
         if (sec == nvm_pkg::SEC_NONE) begin
            unique case (i_wb_adr)
               `NVM_ADDR_CMD: begin
                  if (!busy_r) begin
                     cmd_nxt = i_wb_dat[5:0]; // RQ5
                  end
               end
               `NVM_ADDR_KEY: begin
                  if (i_ext_access && i_wb_dat == `NVM_ACCESS_KEY) begin
                     en_nxt = 1'b1; // RQ22
                  end
               end
               `NVM_ADDR_LINK: begin
                  if (i_ext_access && !i_wb_dat[`NVM_LINK_EN_BIT]) begin
                     en_nxt = 1'b0;
                  end
               end
               `NVM_ADDR_TRIM: trim_nxt = i_wb_dat;
               default: ;
            endcase
         end else if (i_ext_access && en_r && !busy_r) begin // RQ7 RQ6
            if (!i_wb_adr[0]) begin
               if (sec == nvm_pkg::SEC_LOCK || sec == nvm_pkg::SEC_CODE || sec == nvm_pkg::SEC_CFG) begin
                  tmp_nxt = i_wb_dat; // RQ11
               end
            end else begin
               word_in_page_index_nxt = (sec == nvm_pkg::SEC_CODE) ? i_wb_adr[9:1] : {6'h00, i_wb_adr[3:1]}; // RQ8
               wdata_nxt = {i_wb_dat, tmp_r}; // RQ11
               unique case (cmd_r) // RQ3 RQ28
                  `NVM_CMD_WORD: begin
                     if (sec == nvm_pkg::SEC_LOCK) begin
                        start_c = 1'b1; // RQ19
                        op_nxt  = nvm_pkg::OP_WR_LOCK;
                     end else if (sec == nvm_pkg::SEC_CODE && !prog_locked) begin
                        start_c = 1'b1; // RQ18
                        op_nxt  = nvm_pkg::OP_WR_CODE;
                     end else if (sec == nvm_pkg::SEC_CFG && !prog_locked) begin
                        start_c = 1'b1; // RQ18
                        op_nxt  = nvm_pkg::OP_WR_CFG;
                     end
                  end
                  `NVM_CMD_CHIP: begin
                     if (sec == nvm_pkg::SEC_CODE) begin
                        start_c = 1'b1; // RQ15
                        op_nxt  = nvm_pkg::OP_CHIP;
                     end
                  end
                  `NVM_CMD_SECT: begin
                     if (sec == nvm_pkg::SEC_CODE && !prog_locked) begin
                        start_c = 1'b1; // RQ16
                        op_nxt  = nvm_pkg::OP_ER_CODE;
                     end else if (sec == nvm_pkg::SEC_CFG && !prog_locked) begin
                        start_c = 1'b1; // RQ17
                        op_nxt  = nvm_pkg::OP_ER_CFG;
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
      // leaving programming mode makes new config bits take effect
      if (en_r && !en_nxt) begin
         cfg_nxt = cfg_w0[7:0]; // RQ24
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cmd_r   <= `NVM_CMD_RESET; // RQ27
         en_r    <= 1'b0;
         trim_r  <= CAL_VALUE;      // RQ1
         cfg_r   <= cfg_w0[7:0];    // RQ24
         tmp_r   <= 8'hff;
         op_r    <= nvm_pkg::OP_WR_CODE;
         word_in_page_index_r <= 9'h000;
         wdata_r <= `NVM_WORD_ERASED;
      end else begin
         cmd_r   <= cmd_nxt;
         en_r    <= en_nxt;
         trim_r  <= trim_nxt;
         cfg_r   <= cfg_nxt;
         tmp_r   <= tmp_nxt;
         op_r    <= op_nxt;
         word_in_page_index_r <= word_in_page_index_nxt;
         wdata_r <= wdata_nxt;
      end
   end

   // sequencer: the effect lands on the last busy cycle so busy covers it
   assign op_done = (cnt_r == 8'h01);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      lock_nxt  = lock_r;
      code_wr   = 1'b0;
      code_er   = 1'b0;
      cfg_wr    = 1'b0;
      cfg_er    = 1'b0;
      unique case (state_r)
         nvm_pkg::ST_IDLE: begin
            if (start_c) begin
               state_nxt = nvm_pkg::ST_OP; // RQ4
               cnt_nxt   = (op_nxt == nvm_pkg::OP_ER_CODE || op_nxt == nvm_pkg::OP_ER_CFG ||
                            op_nxt == nvm_pkg::OP_CHIP) ? `NVM_ERASE_CYCLES : `NVM_WRITE_CYCLES;
            end
         end
         nvm_pkg::ST_OP: begin
            cnt_nxt = cnt_r - 8'h01;
            if (op_done) begin
               state_nxt = nvm_pkg::ST_IDLE;
               unique case (op_r)
                  nvm_pkg::OP_WR_CODE: code_wr = 1'b1;
                  nvm_pkg::OP_WR_CFG:  cfg_wr  = 1'b1;
                  nvm_pkg::OP_WR_LOCK: lock_nxt = lock_r & wdata_r[7:0];
                  nvm_pkg::OP_ER_CODE: code_er = 1'b1; // RQ13
                  nvm_pkg::OP_ER_CFG:  cfg_er  = 1'b1; // RQ13
                  nvm_pkg::OP_CHIP: begin
                     code_er   = 1'b1; // RQ14
                     state_nxt = nvm_pkg::ST_CHIP_LOCK;
                     cnt_nxt   = `NVM_WRITE_CYCLES;
                  end
                  default: ;
               endcase
            end
         end
         nvm_pkg::ST_CHIP_LOCK: begin
            cnt_nxt = cnt_r - 8'h01;
            if (op_done) begin
               // lock released only once the code section is already blank
               lock_nxt  = `NVM_LOCK_ERASED; // RQ14
               state_nxt = nvm_pkg::ST_IDLE;
            end
         end
         default: state_nxt = nvm_pkg::ST_IDLE;
      endcase
      busy_nxt = (state_nxt != nvm_pkg::ST_IDLE); // RQ4 RQ26
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_r <= nvm_pkg::ST_IDLE;
         cnt_r   <= 8'h00;
         busy_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         busy_r  <= busy_nxt;
      end
   end

   // lock byte is non-volatile: survives reset
   always_ff @(posedge i_clk) begin
      lock_r <= lock_nxt;
   end

   nvm_word_array #(.AW(9)) u_code (
      .i_clk   (i_clk),
      .i_wr    (code_wr),
      .i_erase (code_er),
      .i_word_in_page_index (word_in_page_index_r),
      .i_wdata (wdata_r),
      .i_raddr (i_wb_adr[9:1]),
      .o_rdata (code_rd),
      .o_word0 ()
   );

   nvm_word_array #(.AW(3)) u_cfg (
      .i_clk   (i_clk),
      .i_wr    (cfg_wr),
      .i_erase (cfg_er),
      .i_word_in_page_index (word_in_page_index_r[2:0]),
      .i_wdata (wdata_r),
      .i_raddr (i_wb_adr[3:1]),
      .o_rdata (cfg_rd),
      .o_word0 (cfg_w0)
   );

   assign o_wb_dat   = rdat_r;
   assign o_wb_ack   = ack_r;
   assign o_osc_trim = trim_r;
   assign o_cfg_byte = cfg_r;
   assign o_nvm_busy = busy_r;

   localparam int WR_MAX = 20;
   localparam int ER_MAX = 100;

   sequence s_cmd_write;
      commit && sec == nvm_pkg::SEC_NONE && i_wb_adr == `NVM_ADDR_CMD;
   endsequence

   sequence s_busy_hold;
      o_nvm_busy [*8];
   endsequence

   a_trim_reset : assert property (@(posedge i_clk) i_srst |=> o_osc_trim == CAL_VALUE) // RQ1
      else $error("trim not loaded from calibration at reset");
   a_ack_once : assert property (@(posedge i_clk) disable iff (i_srst)
      req && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack) // single-cycle wishbone ack, decided for this implementation
      else $error("ack not a single cycle after request");
   a_cmd_busy_lock : assert property (@(posedge i_clk) disable iff (i_srst)
      s_cmd_write and busy_r |=> $stable(cmd_r)) // RQ5
      else $error("command changed while busy");
   a_busy_start : assert property (@(posedge i_clk) disable iff (i_srst)
      start_c |=> s_busy_hold ##[1:ER_MAX] !o_nvm_busy) // RQ4
      else $error("busy not held over operation");
   a_write_len : assert property (@(posedge i_clk) disable iff (i_srst)
      start_c && op_nxt == nvm_pkg::OP_WR_CODE |=> o_nvm_busy ##[1:WR_MAX] !o_nvm_busy) // RQ18
      else $error("word write busy time wrong");
   a_internal_fail : assert property (@(posedge i_clk) disable iff (i_srst)
      commit && !i_ext_access |-> !start_c) // RQ7
      else $error("internal write started an nvm operation");
   a_nop_no_start : assert property (@(posedge i_clk) disable iff (i_srst)
      cmd_r == `NVM_CMD_NOP |-> !start_c) // RQ28
      else $error("no-op command started an operation");
   a_read_inhibit : assert property (@(posedge i_clk) disable iff (i_srst)
      req && !o_wb_ack && busy_r && sec != nvm_pkg::SEC_NONE |=> o_wb_dat == 8'h00) // RQ6
      else $error("nvm read not inhibited while busy");
   a_chip_order : assert property (@(posedge i_clk) disable iff (i_srst)
      state_r == nvm_pkg::ST_CHIP_LOCK && op_done |-> $past(code_er, 16)) // RQ14
      else $error("lock released before code erase");
   a_lock_blocks : assert property (@(posedge i_clk) disable iff (i_srst)
      start_c && prog_locked |-> op_nxt == nvm_pkg::OP_CHIP || op_nxt == nvm_pkg::OP_WR_LOCK) // RQ25
      else $error("flash programming started while locked");
endmodule : nvm_program_controller

// >>> logic/nvm_regs.svh
// register offsets, address decode fields, commands and timing counts of the nvm controller
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH

`define NVM_ADDR_CSR      16'h0032
`define NVM_ADDR_CMD      16'h0033
`define NVM_ADDR_KEY      16'h0034
`define NVM_ADDR_LINK     16'h0035
`define NVM_ADDR_TRIM     16'h0039

// upper address bits that select each mapped nvm part
`define NVM_LOCK_SEL      15'h1f80
`define NVM_CFG_SEL       12'h3f4
`define NVM_CAL_SEL       12'h3f8
`define NVM_SIG_SEL       11'h1fe
`define NVM_CODE_SEL      6'h10

`define NVM_CMD_NOP       6'h00
`define NVM_CMD_CHIP      6'h10
`define NVM_CMD_SECT      6'h14
`define NVM_CMD_WORD      6'h1d
`define NVM_CMD_RESET     6'h00

`define NVM_CSR_BUSY_BIT  7
`define NVM_LINK_EN_BIT   1

`define NVM_LOCK_ERASED   8'hff
`define NVM_WORD_ERASED   16'hffff
`define NVM_ACCESS_KEY    8'h5a

`define NVM_WRITE_CYCLES  8'h10
`define NVM_ERASE_CYCLES  8'h40

`endif

// >>> logic/nvm_pkg.sv
// types shared by the nvm controller files
package nvm_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_OP, ST_CHIP_LOCK} nvm_state_e;
   typedef enum logic [2:0] {SEC_NONE, SEC_LOCK, SEC_CODE, SEC_CFG, SEC_CAL, SEC_SIG} nvm_section_e;
   typedef enum logic [2:0] {OP_WR_CODE, OP_WR_CFG, OP_WR_LOCK, OP_ER_CODE, OP_ER_CFG, OP_CHIP} nvm_op_e;
   typedef logic [15:0] nvm_word_t;
endpackage : nvm_pkg

// >>> logic/nvm_word_array.sv
// flop-based flash word storage with word program and whole-section erase
`timescale 1ns/1ns
`include "nvm_regs.svh"
module nvm_word_array #(
   parameter int AW = 3
) (
   input  wire logic            i_clk,     // system clock
   input  wire logic            i_wr,      // program addressed word
   input  wire logic            i_erase,   // erase whole section
   input  wire logic [AW-1:0]   i_word_in_page_index,   // program word index
   input  wire nvm_pkg::nvm_word_t i_wdata, // program data
   input  wire logic [AW-1:0]   i_raddr,   // read word index
   output nvm_pkg::nvm_word_t   o_rdata,   // read data
   output nvm_pkg::nvm_word_t   o_word0    // word 0, for latching
);
   localparam int DEPTH = 1 << AW;

   nvm_pkg::nvm_word_t mem [DEPTH];

   // no reset: contents are non-volatile
   for (genvar g = 0; g < DEPTH; g++) begin : g_word
      nvm_pkg::nvm_word_t word_nxt;
      always_comb begin
         word_nxt = mem[g];
         if (i_erase) begin
            word_nxt = `NVM_WORD_ERASED;
         end else if (i_wr && (i_word_in_page_index == AW'(g))) begin
            // programming only clears bits, so an unerased word gets corrupted
            word_nxt = mem[g] & i_wdata;
         end
      end
      always_ff @(posedge i_clk) begin
         mem[g] <= word_nxt;
      end
   end

   assign o_rdata = mem[i_raddr];
   assign o_word0 = mem[0];
endmodule : nvm_word_array

// >>> tb/nvm_programmer_model.sv
// behavioural external programmer acting as wishbone master
`timescale 1ns/1ns
`include "nvm_regs.svh"
module nvm_programmer_model (
   input  wire logic        i_clk, // system clock
   input  wire logic        i_ack, // slave acknowledge
   input  wire logic [7:0]  i_dat, // slave read data
   output logic             o_cyc, // cycle
   output logic             o_stb, // strobe
   output logic             o_we,  // write enable
   output logic      [15:0] o_adr, // byte address
   output logic      [7:0]  o_dat, // write data
   output logic      [0:0]  o_sel  // byte select
);
   initial begin
      o_cyc = 1'b0;
      o_stb = 1'b0;
      o_we  = 1'b0;
      o_adr = 16'h0000;
      o_dat = 8'h00;
      o_sel = 1'b1;
   end
   // request held until ack is sampled, then released
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk);
      o_cyc <= 1'b1;
      o_stb <= 1'b1;
      o_we  <= w;
      o_adr <= a;
      o_dat <= d;
      o_sel <= 1'b1;
      // no limit of its own: only the bench watchdog ends a hung wait
      do begin
         @(posedge i_clk);
      end while (i_ack !== 1'b1);
      q = i_dat;
      o_cyc <= 1'b0;
      o_stb <= 1'b0;
      // released lines show no stale value
      o_adr <= ~a;
      o_dat <= ~d;
   endtask : xfer
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask : rd
   task automatic idle();
      logic [7:0] q;
      q = 8'hff;
      while (q[`NVM_CSR_BUSY_BIT] !== 1'b0) begin
         rd(`NVM_ADDR_CSR, q);
      end
   endtask : idle
   // caller has erased the word first
   task automatic prog(input logic [15:0] a, input logic [15:0] w);
      wr({a[15:1], 1'b0}, w[7:0]);
      wr({a[15:1], 1'b1}, w[15:8]);
      idle();
   endtask : prog
   task automatic enter();
      wr(`NVM_ADDR_KEY, `NVM_ACCESS_KEY);
   endtask : enter
   task automatic leave();
      wr(`NVM_ADDR_LINK, 8'h00);
   endtask : leave
endmodule : nvm_programmer_model

// >>> tb/nvm_program_controller_tb.sv
// self-checking bench of the nvm controller with a programmer model
`timescale 1ns/1ns
`include "nvm_regs.svh"
module nvm_program_controller_tb;
   localparam logic [7:0] CAL = 8'h80;
   logic        clk, srst, ext, cyc, stb, we, ack, busy;
   logic [15:0] adr;
   logic [7:0]  wdat, rdat, trim, cfg, q;
   logic [0:0]  sel;
   logic [31:0] seed;
   logic [15:0] addrs [7];
   logic [15:0] words [7];
   int          n_errors, checks, nbusy;
   initial clk = 1'b0;
   always #50 clk = ~clk;
   always @(posedge clk) if (busy === 1'b1) nbusy++;
   nvm_program_controller #(.CAL_VALUE(CAL)) dut_u (.i_clk(clk), .i_srst(srst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
      .i_ext_access(ext), .o_wb_dat(rdat), .o_wb_ack(ack), .o_osc_trim(trim),
      .o_cfg_byte(cfg), .o_nvm_busy(busy));
   nvm_programmer_model pm_u (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
      .o_we(we), .o_adr(adr), .o_dat(wdat), .o_sel(sel));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic [7:0] pick(input logic [15:0] w, input logic a0);
      return a0 ? w[15:8] : w[7:0];
   endfunction : pick
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic cmd(input logic [5:0] c);
      pm_u.wr(`NVM_ADDR_CMD, {2'b00, c});
   endtask : cmd
   task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] e);
      logic [7:0] v;
      pm_u.rd(a, v);
      chk(nm, e, v);
   endtask : rdchk
   task automatic words_chk(input int n);
      for (int i = 0; i < n; i++) begin
         rdchk("word low", addrs[i], pick(words[i], 1'b0));
         rdchk("word high", addrs[i] | 16'h0001, pick(words[i], 1'b1));
      end
   endtask : words_chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      srst = 1'b1;
      ext = 1'b1;
      seed = 32'd52;
      n_errors = 0;
      checks = 0;
      nbusy = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rdchk("trim reg", `NVM_ADDR_TRIM, CAL);
      chk("trim pin", CAL, trim);
      rdchk("cmd reset", `NVM_ADDR_CMD, 8'h00);
      rdchk("unmapped", 16'h0010, 8'h00);
      pm_u.enter();
      pm_u.rd(`NVM_ADDR_LINK, q);
      chk("enabled", 8'h01, {7'h00, q[`NVM_LINK_EN_BIT]});
      $display("test reset and entry done");
      cmd(`NVM_CMD_CHIP);
      nbusy = 0;
      pm_u.wr(16'h4001, 8'h00);
      rdchk("read while busy", 16'h4000, 8'h00);
      cmd(`NVM_CMD_WORD);
      pm_u.rd(`NVM_ADDR_CMD, q);
      chk("cmd while busy", {2'b00, `NVM_CMD_CHIP}, {2'b00, q[5:0]});
      pm_u.idle();
      chk("chip erase span", 8'(`NVM_ERASE_CYCLES + `NVM_WRITE_CYCLES), 8'(nbusy));
      rdchk("lock erased", 16'h3f00, `NVM_LOCK_ERASED);
      rdchk("code erased", 16'h43ff, 8'hff);
      cmd(`NVM_CMD_SECT);
      nbusy = 0;
      pm_u.wr(16'h3f41, 8'h00);
      pm_u.idle();
      chk("cfg erase span", `NVM_ERASE_CYCLES, 8'(nbusy));
      rdchk("cfg erased", 16'h3f40, 8'hff);
      $display("test erases done");
      cmd(`NVM_CMD_WORD);
      for (int i = 0; i < 7; i++) begin
         seed = xs(seed);
         addrs[i] = (i == 6) ? 16'h43fe : 16'h4000 + 16'(i * 64) + {10'h000, seed[5:1], 1'b0};
         words[i] = seed[31:16];
         nbusy = 0;
         pm_u.prog(addrs[i], words[i]);
         chk("write span", `NVM_WRITE_CYCLES, 8'(nbusy));
      end
      words_chk(7);
      $display("test word writes done");
      ext <= 1'b0;
      nbusy = 0;
      pm_u.prog(addrs[0], 16'h0000);
      ext <= 1'b1;
      cmd(`NVM_CMD_NOP);
      pm_u.prog(addrs[1], 16'h0000);
      chk("no busy", 8'h00, 8'(nbusy));
      words_chk(2);
      $display("test refused writes done");
      cmd(`NVM_CMD_SECT);
      pm_u.wr(16'h4101, 8'h00);
      pm_u.idle();
      for (int i = 0; i < 7; i++) rdchk("code sect erased", addrs[i], 8'hff);
      seed = xs(seed);
      cmd(`NVM_CMD_WORD);
      pm_u.prog(16'h3f40, {8'hff, seed[7:0]});
      rdchk("cfg word", 16'h3f40, seed[7:0]);
      pm_u.leave();
      // latch lands at the ack edge; look once it has settled
      @(negedge clk);
      chk("cfg latched", seed[7:0], cfg);
      pm_u.enter();
      $display("test config done");
      pm_u.prog(16'h3f00, 16'hfffe);
      rdchk("lock mode two", 16'h3f00, 8'hfe);
      pm_u.prog(addrs[0], 16'h0000);
      rdchk("locked word", addrs[0], 8'hff);
      pm_u.prog(16'h3f00, 16'hfffc);
      rdchk("lock mode three", 16'h3f00, 8'hfc);
      rdchk("unverifiable cfg", 16'h3f40, 8'hff);
      cmd(`NVM_CMD_CHIP);
      pm_u.wr(16'h4001, 8'h00);
      pm_u.idle();
      rdchk("lock released", 16'h3f00, `NVM_LOCK_ERASED);
      $display("test lock done");
      report_and_stop();
   end
endmodule : nvm_program_controller_tb
